// ==== hdl/elapsed_timer_defines.vh ====
`ifndef ELAPSED_TIMER_DEFINES_VH
`define ELAPSED_TIMER_DEFINES_VH

// system clock, one rate for every process
`define CLOCK_FREQ_HZ       250000000

// digit slots in the counter word
`define SLOT_COUNT          8
`define DIGIT_WIDTH         4
`define POSITION_COUNT      5

// one-hot ring value after reset, slot t0
`define RING_RESET          8'h01

// modulus of each time digit, slots t1 to t7
`define MOD_TENTHS          4'hA
`define MOD_SEC_UNITS       4'hA
`define MOD_SEC_TENS        4'h6
`define MOD_MIN_UNITS       4'hA
`define MOD_MIN_TENS        4'h6
`define MOD_HOUR_UNITS      4'hA
`define MOD_HOUR_TENS       4'hA

// prescaler modulus at t0, chosen by {speed_sel_hi, speed_sel_lo}
`define SPEED_CODE_30       2'h0
`define SPEED_CODE_15       2'h1
`define SPEED_CODE_7_5      2'h2
`define SPEED_CODE_3_75     2'h3
`define MOD_SPEED_30        4'h8
`define MOD_SPEED_15        4'h4
`define MOD_SPEED_7_5       4'h2
`define MOD_SPEED_3_75      4'h1

// first displayed slot for each strap setting
`define FIRST_SLOT_MINUTES  3'h1
`define FIRST_SLOT_HOURS    3'h2

// position selects, active low, none asserted
`define SELECT_IDLE_N       5'h1F

`endif

// ==== hdl/tach_retimer.v ====
`timescale 1ns/1ns

module tach_retimer
(
    // clock and reset
    input  wire MCLK,
    input  wire RESET_N,
    // buffered tach input, asynchronous
    input  wire tach_in,
    // one-clock active-low pulse per tach pulse
    output wire tach_pulse_n
);

    reg meta_reg;     // metastability catcher, read only by stage_a_reg
    reg stage_a_reg;  // first retiming stage
    reg stage_b_reg;  // second stage, copy of stage a one clock later

    // one flop guards the pin, then the retiming pair follows
    always @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            meta_reg    <= 1'b0;
            stage_a_reg <= 1'b0;
            stage_b_reg <= 1'b0;
        end
        else
        begin
            meta_reg    <= tach_in;
            stage_a_reg <= meta_reg;
            stage_b_reg <= stage_a_reg;
        end
    end

    // low for exactly one clock, however long the tach pulse stays high
    assign tach_pulse_n = ~(stage_a_reg & ~stage_b_reg);

endmodule // tach_retimer

// ==== hdl/two_entry_buffer.v ====
`timescale 1ns/1ns

module two_entry_buffer
#(
    parameter WIDTH = 9
)
(
    // clock and reset
    input  wire             MCLK,
    input  wire             RESET_N,
    // filling side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // draining side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] head_reg;   // oldest word, drives the output
    reg [WIDTH-1:0] tail_reg;   // second word, held while stalled
    reg [1:0]       count_reg;  // words held, 0 to 2

    wire push;  // word accepted this cycle
    wire pop;   // word taken this cycle

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = head_reg;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // head always holds the oldest word so the output stays registered
    always @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            head_reg  <= {WIDTH{1'b0}};
            tail_reg  <= {WIDTH{1'b0}};
            count_reg <= 2'h0;
        end
        else
        begin
            case ({push, pop})
                2'b10:
                begin
                    // fill head first, else tail
                    if (count_reg == 2'h0)
                        head_reg <= in_data;
                    else
                        tail_reg <= in_data;
                    count_reg <= count_reg + 2'h1;
                end
                2'b01:
                begin
                    // tail moves up
                    head_reg  <= tail_reg;
                    count_reg <= count_reg - 2'h1;
                end
                2'b11:
                begin
                    // pass through, count unchanged
                    if (count_reg == 2'h1)
                        head_reg <= in_data;
                    else
                    begin
                        head_reg <= tail_reg;
                        tail_reg <= in_data;
                    end
                end
                default:
                begin
                    count_reg <= count_reg;
                end
            endcase
        end
    end

endmodule // two_entry_buffer

// ==== hdl/tape_elapsed_time_counter.v ====
`timescale 1ns/1ns
`include "elapsed_timer_defines.vh"

// Operation
// - count tach pulses, add forward, subtract reverse
// - five digits serially over shared BCD bus
// - five position selects name the present digit
// - selects active low, at most one low
// - tach retimed by two flops, one-clock pulse
// - pulse low while first stage set, second not
// - retimed pulse held in flag until used
// - eight BCD digits recirculate through one adder
// - one-hot eight-slot ring times counting and display
// - everything timed from the single system clock
// - t0 prescaler modulus eight, four, two, one
// - t1 to t7 moduli ten/ten/six/ten/six/ten/ten
// - strap shows slots t1-t5 or t2-t6
// - selects decoded from strapped ring slots, passed through the output buffer
// - inputs: direction, speed select, tach pulses
// - pulse last cycle: step one, else recirculate
// - clear low blocks tach, zeroes all digits
// - direction flag loaded every edge, high counts up

module tape_elapsed_time_counter
(
    // clock and reset
    input  wire       MCLK,
    input  wire       RESET_N,
    // transport and control unit inputs, asynchronous
    input  wire       TACH_IN,
    input  wire       TAPE_DIRECTION_CMD,
    input  wire       SPEED_SEL_LO,
    input  wire       SPEED_SEL_HI,
    input  wire       COUNT_CLEAR_N,
    // static strap, high shows seconds to hours
    input  wire       HOURS_DISPLAY_STRAP,
    // display side flow control
    input  wire       DISPLAY_READY,
    output wire       DISPLAY_VALID,
    // shared BCD bus, bit 0 is line A
    output wire [3:0] BCD_DATA,
    // position selects, active low
    output wire       POSITION_SELECT_FIRST_N,
    output wire       POSITION_SELECT_SECOND_N,
    output wire       POSITION_SELECT_THIRD_N,
    output wire       POSITION_SELECT_FOURTH_N,
    output wire       POSITION_SELECT_FIFTH_N
);

    localparam SLOTS = `SLOT_COUNT;        // digit slots per cycle
    localparam DW    = `DIGIT_WIDTH;       // bits per digit
    localparam NPOS  = `POSITION_COUNT;    // displayed positions
    localparam BW    = NPOS + DW;          // buffer word: selects and digit

    integer i;  // loop index for decode and reset

    // ------------------------------------------------------------
    // input synchronisers for the level pins
    // ------------------------------------------------------------
    reg  [4:0] pin_meta_reg;  // first flops, read only by pin_sync_reg
    reg  [4:0] pin_sync_reg;  // second flops, safe to use
    wire [4:0] pin_raw;       // pins gathered in one vector

    wire dir_sync;            // direction command, synchronised
    wire speed_lo_sync;       // speed select low bit
    wire speed_hi_sync;       // speed select high bit
    wire clear_n_sync;        // clear, active low
    wire hours_sync;          // strap level

    assign pin_raw = {HOURS_DISPLAY_STRAP, COUNT_CLEAR_N, SPEED_SEL_HI,
                      SPEED_SEL_LO, TAPE_DIRECTION_CMD};

    // two flops per pin; clear powers up asserted so the count starts at zero
    always @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
        end
        else
        begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign dir_sync      = pin_sync_reg[0];
    assign speed_lo_sync = pin_sync_reg[1];
    assign speed_hi_sync = pin_sync_reg[2];
    assign clear_n_sync  = pin_sync_reg[3];
    assign hours_sync    = pin_sync_reg[4];

    // ------------------------------------------------------------
    // tach retiming
    // ------------------------------------------------------------
    wire tach_pulse_n;  // one clock low per tach pulse

    tach_retimer u_retimer
    (
        .MCLK         (MCLK),
        .RESET_N      (RESET_N),
        .tach_in      (TACH_IN),
        .tach_pulse_n (tach_pulse_n)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [DW-1:0]    digit_mem [0:SLOTS-1];  // count word, one digit per slot
    reg [SLOTS-1:0] ring_reg;               // one-hot slot marker
    reg             up_reg;                 // direction flag, high counts up
    reg             tach_flag_reg;          // stored tach pulse
    reg             apply_reg;              // pulse taken for this cycle
    reg             carry_reg;              // carry or borrow to next slot
    reg             hours_reg;              // strap, taken only between ring cycles

    // ------------------------------------------------------------
    // datapath signals
    // ------------------------------------------------------------
    reg  [2:0]    slot_idx;     // slot now at the adder
    reg  [DW-1:0] cur_digit;    // digit read from the word
    reg  [DW-1:0] modulus;      // modulus for this slot
    reg  [DW-1:0] new_digit;    // adder result
    reg           carry_in;     // step request into this slot
    reg           carry_out;    // carry or borrow out of this slot
    reg  [DW-1:0] speed_mod;    // prescaler modulus from speed
    reg  [2:0]    first_slot;   // first displayed slot
    reg  [2:0]    pos_idx;      // display position of this slot
    reg           disp_hit;     // slot is shown on the display
    reg  [NPOS-1:0] sel_n;      // select word for this slot

    wire          step_en;      // ring advances this clock
    wire          last_slot;    // slot t7 at the adder
    wire          push_ready;   // buffer can take a word
    wire          tach_flag_next;

    // ------------------------------------------------------------
    // slot decode and modulus selection
    // ------------------------------------------------------------
    // the ring is one-hot, so the index is a plain priority-free decode
    always @*
    begin
        slot_idx = 3'h0;
        for (i = 0; i < SLOTS; i = i + 1)
        begin
            if (ring_reg[i])
                slot_idx = i[2:0];
        end
    end

    // prescaler digit divides the tach rate to tenths of a second
    always @*
    begin
        case ({speed_hi_sync, speed_lo_sync})
            `SPEED_CODE_30:   speed_mod = `MOD_SPEED_30;
            `SPEED_CODE_15:   speed_mod = `MOD_SPEED_15;
            `SPEED_CODE_7_5:  speed_mod = `MOD_SPEED_7_5;
            default:          speed_mod = `MOD_SPEED_3_75;
        endcase
    end

    // modulus for the slot now at the adder
    always @*
    begin
        case (slot_idx)
            3'h0:    modulus = speed_mod;
            3'h1:    modulus = `MOD_TENTHS;
            3'h2:    modulus = `MOD_SEC_UNITS;
            3'h3:    modulus = `MOD_SEC_TENS;
            3'h4:    modulus = `MOD_MIN_UNITS;
            3'h5:    modulus = `MOD_MIN_TENS;
            3'h6:    modulus = `MOD_HOUR_UNITS;
            default: modulus = `MOD_HOUR_TENS;
        endcase
    end

    // ------------------------------------------------------------
    // serial-by-digit adder
    // ------------------------------------------------------------
    // t0 takes the stored tach pulse, later slots take the ripple carry;
    // the carry out of t7 falls off the top, so the count wraps at 100 hours
    always @*
    begin
        cur_digit = digit_mem[slot_idx];
        carry_in  = (slot_idx == 3'h0) ? apply_reg : carry_reg;
        new_digit = cur_digit;
        carry_out = 1'b0;
        if (carry_in && up_reg)
        begin
            // count up; a digit left above range by a speed change wraps too
            if ((cur_digit + 4'h1) >= modulus)
            begin
                new_digit = 4'h0;
                carry_out = 1'b1;
            end
            else
                new_digit = cur_digit + 4'h1;
        end
        else if (carry_in)
        begin
            // count down, borrow below zero
            if (cur_digit == 4'h0 || cur_digit >= modulus)
            begin
                new_digit = modulus - 4'h1;
                carry_out = (cur_digit == 4'h0);
            end
            else
                new_digit = cur_digit - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // display slot selection
    // ------------------------------------------------------------
    // the strap moves the five-digit window one slot up
    always @*
    begin
        // a strap move mid-cycle would repeat or skip a position
        first_slot = hours_reg ? `FIRST_SLOT_HOURS : `FIRST_SLOT_MINUTES;
        pos_idx    = slot_idx - first_slot;
        disp_hit   = (slot_idx >= first_slot) && (pos_idx < NPOS[2:0]);
        sel_n      = `SELECT_IDLE_N;
        if (disp_hit)
            sel_n = ~(5'h01 << pos_idx);
    end

    // a shown slot waits until the buffer takes its digit, so none is lost
    assign step_en   = ~disp_hit | push_ready;
    assign last_slot = ring_reg[SLOTS-1];

    // ------------------------------------------------------------
    // tach storage flag
    // ------------------------------------------------------------
    // a new pulse wins over the hand-off at t7; clear blocks pulses
    assign tach_flag_next = clear_n_sync &
                            (~tach_pulse_n |
                             (tach_flag_reg & ~(step_en & last_slot)));

    // ------------------------------------------------------------
    // counter state
    // ------------------------------------------------------------
    // all state moves on the one system clock; the ring only stalls
    always @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ring_reg      <= `RING_RESET;
            up_reg        <= 1'b0;
            tach_flag_reg <= 1'b0;
            apply_reg     <= 1'b0;
            carry_reg     <= 1'b0;
            hours_reg     <= 1'b0;
            for (i = 0; i < SLOTS; i = i + 1)
                digit_mem[i] <= 4'h0;
        end
        else
        begin
            up_reg        <= dir_sync;
            // strap window moves only as slot t0 comes round
            if (step_en && last_slot)
                hours_reg <= hours_sync;
            tach_flag_reg <= tach_flag_next;
            if (!clear_n_sync)
            begin
                // clear holds every digit and pending step at zero
                apply_reg <= 1'b0;
                carry_reg <= 1'b0;
                for (i = 0; i < SLOTS; i = i + 1)
                    digit_mem[i] <= 4'h0;
            end
            else if (step_en)
            begin
                digit_mem[slot_idx] <= new_digit;
                carry_reg           <= carry_out;
                if (last_slot)
                    apply_reg <= tach_flag_reg;
            end
            // ring keeps turning during clear so the display shows zeros
            if (step_en)
                ring_reg <= {ring_reg[SLOTS-2:0], ring_reg[SLOTS-1]};
        end
    end

    // ------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------
    wire [BW-1:0] buf_in;     // selects and digit, one word
    wire [BW-1:0] buf_out;    // word at the head
    wire          buf_valid;  // head holds a word

    // digit and select travel in one word so they can never part
    assign buf_in = {sel_n, new_digit};

    two_entry_buffer #(.WIDTH(BW)) u_buffer
    (
        .MCLK      (MCLK),
        .RESET_N   (RESET_N),
        .in_valid  (disp_hit),
        .in_ready  (push_ready),
        .in_data   (buf_in),
        .out_valid (buf_valid),
        .out_ready (DISPLAY_READY),
        .out_data  (buf_out)
    );

    // with no word held every select stays high, so nothing lights
    assign DISPLAY_VALID            = buf_valid;
    assign BCD_DATA                 = buf_out[DW-1:0];
    assign POSITION_SELECT_FIRST_N  = buf_out[DW]   | ~buf_valid;
    assign POSITION_SELECT_SECOND_N = buf_out[DW+1] | ~buf_valid;
    assign POSITION_SELECT_THIRD_N  = buf_out[DW+2] | ~buf_valid;
    assign POSITION_SELECT_FOURTH_N = buf_out[DW+3] | ~buf_valid;
    assign POSITION_SELECT_FIFTH_N  = buf_out[DW+4] | ~buf_valid;

endmodule // tape_elapsed_time_counter

// ==== bench/elapsed_time_props.sv ====
`timescale 1ns/1ns

module elapsed_time_props
(
    // clock and reset
    input wire       MCLK,
    input wire       RESET_N,
    // control levels
    input wire       COUNT_CLEAR_N,
    input wire       HOURS_DISPLAY_STRAP,
    // display side
    input wire       DISPLAY_READY,
    input wire       DISPLAY_VALID,
    input wire [3:0] BCD_DATA,
    input wire       POSITION_SELECT_FIRST_N,
    input wire       POSITION_SELECT_SECOND_N,
    input wire       POSITION_SELECT_THIRD_N,
    input wire       POSITION_SELECT_FOURTH_N,
    input wire       POSITION_SELECT_FIFTH_N
);
    // selects gathered, bit 0 is the first position
    wire [4:0] sel_n = {POSITION_SELECT_FIFTH_N, POSITION_SELECT_FOURTH_N,
        POSITION_SELECT_THIRD_N, POSITION_SELECT_SECOND_N, POSITION_SELECT_FIRST_N};
    // index of the asserted select
    wire [2:0] pos_idx = !sel_n[0] ? 3'h0 : !sel_n[1] ? 3'h1 : !sel_n[2] ? 3'h2 :
        !sel_n[3] ? 3'h3 : 3'h4;
    // positions that carry a modulo six digit under each strap
    wire       tens_pos = HOURS_DISPLAY_STRAP ? (!sel_n[1] || !sel_n[3])
        : (!sel_n[2] || !sel_n[4]);
    reg  [2:0] last_pos_reg;  // position of the last word taken
    reg        seen_reg;      // a word has been taken since reset
    wire [2:0] next_pos = (last_pos_reg == 3'h4) ? 3'h0 : last_pos_reg + 3'h1;

    // remember the last popped position so that order can be judged
    always @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            last_pos_reg <= 3'h0;
            seen_reg     <= 1'b0;
        end
        else if (DISPLAY_VALID && DISPLAY_READY)
        begin
            last_pos_reg <= pos_idx;
            seen_reg     <= 1'b1;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    // word taken, word held back, clear held long enough to drain the buffer
    sequence pop_s;
        DISPLAY_VALID && DISPLAY_READY;
    endsequence
    sequence stall_s;
        DISPLAY_VALID && !DISPLAY_READY;
    endsequence
    sequence cleared_s;
        (!COUNT_CLEAR_N && DISPLAY_READY) [*8];
    endsequence

    a_one_select: assert property ($onehot0(~sel_n))
        else $error("more than one position select low");
    a_idle_high: assert property (!DISPLAY_VALID |-> sel_n == 5'h1F)
        else $error("select low without a word");
    a_valid_named: assert property (DISPLAY_VALID |-> $onehot(~sel_n))
        else $error("word shown without one select");
    a_word_holds: assert property (stall_s |=> DISPLAY_VALID && $stable(BCD_DATA)
        && $stable(sel_n))
        else $error("word changed while stalled");
    a_digit_bcd: assert property (DISPLAY_VALID |-> BCD_DATA <= 4'h9)
        else $error("digit above nine");
    a_tens_six: assert property (DISPLAY_VALID && tens_pos |-> BCD_DATA <= 4'h5)
        else $error("tens digit above five");
    a_pos_order: assert property (pop_s |-> !seen_reg || pos_idx == next_pos)
        else $error("positions out of order");
    a_clear_zero: assert property (cleared_s |-> !DISPLAY_VALID || BCD_DATA == 4'h0)
        else $error("digit not zero under clear");
endmodule // elapsed_time_props

bind tape_elapsed_time_counter elapsed_time_props u_props
(
    .MCLK                     (MCLK),
    .RESET_N                  (RESET_N),
    .COUNT_CLEAR_N            (COUNT_CLEAR_N),
    .HOURS_DISPLAY_STRAP      (HOURS_DISPLAY_STRAP),
    .DISPLAY_READY            (DISPLAY_READY),
    .DISPLAY_VALID            (DISPLAY_VALID),
    .BCD_DATA                 (BCD_DATA),
    .POSITION_SELECT_FIRST_N  (POSITION_SELECT_FIRST_N),
    .POSITION_SELECT_SECOND_N (POSITION_SELECT_SECOND_N),
    .POSITION_SELECT_THIRD_N  (POSITION_SELECT_THIRD_N),
    .POSITION_SELECT_FOURTH_N (POSITION_SELECT_FOURTH_N),
    .POSITION_SELECT_FIFTH_N  (POSITION_SELECT_FIFTH_N)
);

// ==== bench/display_model.sv ====
`timescale 1ns/1ns

module display_model
(
    // clock and reset
    input  wire       MCLK,
    input  wire       RESET_N,
    // word from the counter
    input  wire       DISPLAY_VALID,
    input  wire [3:0] BCD_DATA,
    input  wire [4:0] sel_n,
    // bench asks for stalls
    input  wire       stall_en,
    // flow control and what was taken
    output reg        DISPLAY_READY,
    output reg        got,
    output reg  [3:0] got_digit,
    output reg  [2:0] got_pos,
    output reg  [6:0] seg_n
);
    reg [7:0] lfsr_reg;  // stall pattern

    // segments driven low to form the digit, shared by all positions
    function [6:0] seg_of(input [3:0] d);
        case (d)
            4'h0: seg_of = ~7'h3F;
            4'h1: seg_of = ~7'h06;
            4'h2: seg_of = ~7'h5B;
            4'h3: seg_of = ~7'h4F;
            4'h4: seg_of = ~7'h66;
            4'h5: seg_of = ~7'h6D;
            4'h6: seg_of = ~7'h7D;
            4'h7: seg_of = ~7'h07;
            4'h8: seg_of = ~7'h7F;
            default: seg_of = ~7'h6F;
        endcase
    endfunction

    // ready moves on the falling edge; stalls are long so the buffer fills
    always @(negedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            lfsr_reg      <= 8'h5A;
            DISPLAY_READY <= 1'b1;
        end
        else
        begin
            lfsr_reg      <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
            DISPLAY_READY <= !stall_en || (lfsr_reg[2:0] == 3'h0);
        end
    end

    // a word is taken where valid and ready meet on the rising edge
    always @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            got <= 1'b0;
        else
        begin
            got       <= DISPLAY_VALID && DISPLAY_READY;
            got_digit <= BCD_DATA;
            got_pos   <= !sel_n[0] ? 3'h0 : !sel_n[1] ? 3'h1 : !sel_n[2] ? 3'h2 :
                !sel_n[3] ? 3'h3 : 3'h4;
            seg_n     <= seg_of(BCD_DATA);
        end
    end
endmodule // display_model

// ==== bench/tape_elapsed_time_counter_bench.sv ====
`timescale 1ns/1ns

module tape_elapsed_time_counter_bench;
    // design inputs
    reg        MCLK = 0, RESET_N = 0, TACH_IN = 0, TAPE_DIRECTION_CMD = 1;
    reg        SPEED_SEL_LO = 0, SPEED_SEL_HI = 0, COUNT_CLEAR_N = 1;
    reg        HOURS_DISPLAY_STRAP = 0, stall_en = 0;
    // design outputs and model taps
    wire       DISPLAY_READY, DISPLAY_VALID, got;
    wire [3:0] BCD_DATA, got_digit;
    wire [2:0] got_pos;
    wire [4:0] sel_n;
    integer    seed = 7, num_errors = 0, comparisons = 0, cycles = 0, i, n;

    initial forever #2 MCLK = ~MCLK;

    tape_elapsed_time_counter dut (.MCLK(MCLK), .RESET_N(RESET_N), .TACH_IN(TACH_IN),
        .TAPE_DIRECTION_CMD(TAPE_DIRECTION_CMD), .SPEED_SEL_LO(SPEED_SEL_LO),
        .SPEED_SEL_HI(SPEED_SEL_HI), .COUNT_CLEAR_N(COUNT_CLEAR_N),
        .HOURS_DISPLAY_STRAP(HOURS_DISPLAY_STRAP), .DISPLAY_READY(DISPLAY_READY),
        .DISPLAY_VALID(DISPLAY_VALID), .BCD_DATA(BCD_DATA),
        .POSITION_SELECT_FIRST_N(sel_n[0]), .POSITION_SELECT_SECOND_N(sel_n[1]),
        .POSITION_SELECT_THIRD_N(sel_n[2]), .POSITION_SELECT_FOURTH_N(sel_n[3]),
        .POSITION_SELECT_FIFTH_N(sel_n[4]));

    display_model u_display (.MCLK(MCLK), .RESET_N(RESET_N), .DISPLAY_VALID(DISPLAY_VALID),
        .BCD_DATA(BCD_DATA), .sel_n(sel_n), .stall_en(stall_en),
        .DISPLAY_READY(DISPLAY_READY), .got(got), .got_digit(got_digit),
        .got_pos(got_pos), .seg_n());

    // watchdog, generous against the fewer than eight hundred pulses run below
    always @(posedge MCLK)
    begin
        cycles = cycles + 1;
        if (cycles == 60000)
        begin
            num_errors = num_errors + 1;
            final_report;
        end
    end

    task final_report;
        $display("checks %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task check_digit(input [3:0] g, input [3:0] e);
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            num_errors = num_errors + 1;
            $display("ERROR %0t digit %h expected %h", $time, g, e);
        end
    endtask

    task check_pos(input [2:0] g, input [2:0] e);
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            num_errors = num_errors + 1;
            $display("ERROR %0t position %0d expected %0d", $time, g, e);
        end
    endtask

    // digit of a tenths total held in a given slot
    function [3:0] exp_digit(input integer t, input integer slot);
        case (slot)
            1: exp_digit = t % 10;
            2: exp_digit = (t / 10) % 10;
            3: exp_digit = (t / 100) % 6;
            4: exp_digit = (t / 600) % 10;
            5: exp_digit = (t / 6000) % 6;
            default: exp_digit = (t / 36000) % 10;
        endcase
    endfunction

    // tach pulses spaced wider than one ring cycle so none merge
    task tach(input integer k);
        repeat (k)
        begin
            @(negedge MCLK) TACH_IN = 1;
            repeat (4) @(negedge MCLK);
            TACH_IN = 0;
            repeat (12) @(negedge MCLK);
        end
    endtask

    // strap moves only under clear, when every shown digit is zero
    task clear(input s);
        @(negedge MCLK) COUNT_CLEAR_N = 0;
        repeat (6) @(negedge MCLK);
        HOURS_DISPLAY_STRAP = s;
        repeat (10) @(negedge MCLK);
        COUNT_CLEAR_N = 1;
        repeat (4) @(negedge MCLK);
    endtask

    // take one full display cycle from the first position on
    task read_show(input integer t);
        integer j, k;
        for (j = 0; j < 5; j = j + 1)
        begin
            k = 0;
            do
            begin
                @(negedge MCLK);
                k = k + 1;
            end while (!(got === 1'b1 && (j > 0 || got_pos === 3'h0)) && k < 400);
            if (k >= 400)
            begin
                num_errors = num_errors + 1;
                $display("ERROR %0t no display word", $time);
            end
            check_pos(got_pos, j);
            check_digit(got_digit, exp_digit(t, j + 1 + HOURS_DISPLAY_STRAP));
        end
        $display("test ended, tenths %0d strap %0d", t, HOURS_DISPLAY_STRAP);
    endtask

    initial
    begin
        repeat (2) @(negedge MCLK);
        RESET_N = 1;
        repeat (4) @(negedge MCLK);
        read_show(0);
        // every speed code, random pulse count and strap
        for (i = 0; i < 4; i = i + 1)
        begin
            n = $random(seed);
            {SPEED_SEL_HI, SPEED_SEL_LO} = i;
            clear(n[0]);
            n = 5 + {$random(seed)} % 36;
            tach(n);
            repeat (40) @(negedge MCLK);
            read_show(n / (8 >> i));
        end
        // one minute up, one tenth back: borrow runs to the minutes
        clear(1'b0);
        tach(600);
        TAPE_DIRECTION_CMD = 0;
        repeat (8) @(negedge MCLK);
        tach(1);
        repeat (40) @(negedge MCLK);
        stall_en = 1;
        read_show(599);
        stall_en = 0;
        // pulses under clear are dropped; one leaking would underflow
        COUNT_CLEAR_N = 0;
        tach(5);
        COUNT_CLEAR_N = 1;
        repeat (40) @(negedge MCLK);
        read_show(0);
        final_report;
    end
endmodule // tape_elapsed_time_counter_bench
